// ===== inc/asf_params.svh
// Register offsets, field positions and reset values of the sample buffer
// Assumes inclusion by bare name from any design file
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH

`define ASF_DEPTH         32
`define ASF_SMP_W         12
`define ASF_CNT_W         6
`define ASF_PTR_W         5

`define ASF_OFS_X_LOW     8'h02
`define ASF_OFS_X_HIGH    8'h03
`define ASF_OFS_Y_LOW     8'h04
`define ASF_OFS_Y_HIGH    8'h05
`define ASF_OFS_Z_LOW     8'h06
`define ASF_OFS_Z_HIGH    8'h07
`define ASF_OFS_STATUS    8'h08
`define ASF_OFS_CONTROL   8'h14

`define ASF_RST_AXIS      8'h00
`define ASF_RST_CONTROL   8'h00

`define ASF_CTL_MODE_HI   7
`define ASF_CTL_MODE_LO   6
`define ASF_CTL_WM_HI     5
`define ASF_CTL_WM_LO     0

`define ASF_STS_WM_BIT    7
`define ASF_STS_FULL_BIT  6

`endif

// ===== inc/asf_pkg.sv
// Types shared by the sample buffer modules
// Assumes nothing beyond the params header
package asf_pkg;
	typedef enum logic [1:0] {ASF_BYPASS, ASF_FIFO, ASF_STREAM, ASF_TRIGGER} asf_mode_e;
	typedef logic [35:0] asf_sample_t;
endpackage

// ===== inc/asf_mem_if.sv
// Carrier between buffer control and sample storage
// Assumes a single clock domain
`timescale 1ns/10ps
interface asf_mem_if #(parameter int CNT_W = 6) ();
	import asf_pkg::*;
	logic              push;
	logic              over;
	asf_sample_t       push_data;
	logic              pop;
	asf_sample_t       pop_data;
	logic              keep;
	logic [CNT_W-1:0]  keep_n;
	logic              clear;
	logic [CNT_W-1:0]  count;
	logic              full;
	modport ctrl  (output push, over, push_data, pop, keep, keep_n, clear, input pop_data, count, full);
	modport store (input push, over, push_data, pop, keep, keep_n, clear, output pop_data, count, full);
endinterface

// ===== src/asf_store.sv
// Circular sample storage with push, pop, trim and clear
// Assumes one operation set per cycle from the controller
`timescale 1ns/10ps
`include "asf_params.svh"
module asf_store import asf_pkg::*; #(
	parameter int DEPTH = `ASF_DEPTH,
	parameter int PTR_W = `ASF_PTR_W,
	parameter int CNT_W = `ASF_CNT_W
) (
	input  wire logic  sys_clk,
	input  wire logic  rst_b,
	asf_mem_if.store   mem
);
	asf_sample_t       ram [DEPTH];
	logic [PTR_W-1:0]  wr_q;
	logic [PTR_W-1:0]  rd_q;
	logic [CNT_W-1:0]  cnt_q;
	logic              full;
	logic              do_pop;
	logic              do_push;
	logic              drop;

	assign full         = (cnt_q == CNT_W'(DEPTH));
	assign do_pop       = mem.pop && (cnt_q != '0);
	assign do_push      = mem.push && (!full || mem.over || do_pop);
	assign drop         = do_push && full && !do_pop;
	assign mem.count    = cnt_q;
	assign mem.full     = full;
	assign mem.pop_data = ram[rd_q];

	always_ff @(posedge sys_clk) begin
		if (do_push && !mem.clear && !mem.keep) begin
			ram[wr_q] <= mem.push_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (mem.clear) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (mem.keep) begin
			if (cnt_q > mem.keep_n) begin
				rd_q  <= wr_q - PTR_W'(mem.keep_n);
				cnt_q <= mem.keep_n;
			end
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_pop || drop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + CNT_W'(do_push && !drop) - CNT_W'(do_pop);
		end
	end
endmodule // asf_store

// ===== src/asf_top.sv
// Accelerometer sample buffer: modes, status, axis data registers
// Assumes host register strobes and samples come from logic on sys_clk
`timescale 1ns/10ps
`include "asf_params.svh"
module asf_top import asf_pkg::*; #(
	parameter int DEPTH = `ASF_DEPTH,
	parameter int SMP_W = `ASF_SMP_W,
	parameter int CNT_W = `ASF_CNT_W
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              smp_valid,
	input  wire logic [SMP_W-1:0]  smp_x,
	input  wire logic [SMP_W-1:0]  smp_y,
	input  wire logic [SMP_W-1:0]  smp_z,
	input  wire logic              trig_evt,
	input  wire logic [7:0]        host_addr,
	input  wire logic              host_wr,
	input  wire logic [7:0]        host_wdata,
	input  wire logic              host_rd,
	input  wire logic              host_txn_end,
	output logic      [7:0]        host_rdata,
	output logic                   buf_full,
	output logic                   buf_watermark
);
	asf_mem_if #(.CNT_W(CNT_W)) mem ();

	asf_store #(
		.DEPTH (DEPTH),
		.PTR_W ($clog2(DEPTH)),
		.CNT_W (CNT_W)
	) u_store (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.mem     (mem)
	);

	logic [7:0]        ctrl_q;
	asf_mode_e         mode;
	logic [CNT_W-1:0]  wm_level;
	logic              armed_q;
	logic              held_q;
	logic              touched_q;
	asf_sample_t       axis_q;
	logic              rd_axis;
	logic              rd_zhigh;
	logic              consume;
	logic              fire;
	logic              load;
	logic              wm_hit;
	logic [7:0]        status;
	logic [7:0]        rdata_d;

	assign mode     = asf_mode_e'(ctrl_q[`ASF_CTL_MODE_HI:`ASF_CTL_MODE_LO]);
	assign wm_level = CNT_W'(ctrl_q[`ASF_CTL_WM_HI:`ASF_CTL_WM_LO]);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= `ASF_RST_CONTROL;
		end else if (host_wr && host_addr == `ASF_OFS_CONTROL) begin
			ctrl_q <= host_wdata;
		end
	end

	assign fire = (mode == ASF_TRIGGER) && armed_q && trig_evt;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			armed_q <= 1'b1;
		end else if (mode == ASF_BYPASS) begin
			armed_q <= 1'b1;
		end else if (fire) begin
			armed_q <= 1'b0;
		end
	end

	assign mem.push      = smp_valid && (mode != ASF_BYPASS);
	assign mem.push_data = {smp_x, smp_y, smp_z};
	assign mem.over      = (mode == ASF_STREAM) || ((mode == ASF_TRIGGER) && armed_q);
	assign mem.keep      = fire;
	assign mem.keep_n    = wm_level;
	assign mem.clear     = (mode == ASF_BYPASS);
	// no stall back to the sensor

	assign rd_axis  = host_rd && (host_addr >= `ASF_OFS_X_LOW) && (host_addr <= `ASF_OFS_Z_HIGH);
	assign rd_zhigh = host_rd && (host_addr == `ASF_OFS_Z_HIGH);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			touched_q <= 1'b0;
		end else if (rd_zhigh || host_txn_end || mode == ASF_BYPASS) begin
			touched_q <= 1'b0;
		end else if (rd_axis) begin
			touched_q <= 1'b1;
		end
	end

	assign consume = rd_zhigh || (host_txn_end && (touched_q || rd_axis));

	assign load    = (mode != ASF_BYPASS) && !fire && (mem.count != '0) && (!held_q || consume);
	assign mem.pop = load;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			held_q <= 1'b0;
		end else if (mode == ASF_BYPASS) begin
			held_q <= 1'b0;
		end else if (load) begin
			held_q <= 1'b1;
		end else if (consume) begin
			held_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			axis_q <= '0;
		end else if (mode == ASF_BYPASS) begin
			if (smp_valid) begin
				axis_q <= {smp_x, smp_y, smp_z};
			end
		end else if (load) begin
			axis_q <= mem.pop_data;
		end
	end

	assign wm_hit = (wm_level != '0) && (mem.count >= wm_level);

	assign status = {wm_hit, mem.full, mem.count};

	always_comb begin
		rdata_d = 8'h00;
		unique case (host_addr)
			`ASF_OFS_X_LOW:   rdata_d = {axis_q[27:24], 4'h0};
			`ASF_OFS_X_HIGH:  rdata_d = axis_q[35:28];
			`ASF_OFS_Y_LOW:   rdata_d = {axis_q[15:12], 4'h0};
			`ASF_OFS_Y_HIGH:  rdata_d = axis_q[23:16];
			`ASF_OFS_Z_LOW:   rdata_d = {axis_q[3:0], 4'h0};
			`ASF_OFS_Z_HIGH:  rdata_d = axis_q[11:4];
			`ASF_OFS_STATUS:  rdata_d = status;
			`ASF_OFS_CONTROL: rdata_d = ctrl_q;
			default:          rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			host_rdata <= `ASF_RST_AXIS;
		end else if (host_rd) begin
			host_rdata <= rdata_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			buf_full      <= 1'b0;
			buf_watermark <= 1'b0;
		end else begin
			buf_full      <= mem.full;
			buf_watermark <= wm_hit;
		end
	end

endmodule // asf_top

// ===== tb/asf_sva.sv
// Port assertions for the sample buffer
// Assumes bind onto asf_top, one clock domain
`timescale 1ns/10ps
module asf_sva (
	input wire logic	sys_clk,
	input wire logic	rst_b,
	input wire logic	smp_valid,
	input wire logic	trig_evt,
	input wire logic [7:0]	host_addr,
	input wire logic	host_wr,
	input wire logic [7:0]	host_wdata,
	input wire logic	host_rd,
	input wire logic [7:0]	host_rdata,
	input wire logic	buf_full,
	input wire logic	buf_watermark
);
	logic [7:0]	ctl_q;
	// Shadow of the control register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ctl_q <= 8'h00;
		else if (host_wr && host_addr == 8'h14)
			ctl_q <= host_wdata;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata)) else $error("read data moved");
	a_unmapped_zero: assert property (host_rd && host_addr == 8'h01 |=> host_rdata == 8'h00)
		else $error("unmapped read");
	a_low_pad: assert property (host_rd && host_addr inside {8'h02, 8'h04, 8'h06} |=> host_rdata[3:0] == 4'h0)
		else $error("low byte pad");
	a_bypass_empty: assert property (ctl_q < 8'h40 && $past(ctl_q) < 8'h40 && host_rd && host_addr == 8'h08
		|=> host_rdata == 8'h00) else $error("bypass not empty");
	a_bypass_flags: assert property ((ctl_q < 8'h40) [*3] |-> !buf_full && !buf_watermark)
		else $error("flags in bypass");
	a_wm_off: assert property ((ctl_q[5:0] == 6'h00) [*3] |-> !buf_watermark) else $error("level zero");
	a_ctrl_back: assert property (host_rd && host_addr == 8'h14 |=> host_rdata == $past(ctl_q))
		else $error("control readback");
	a_full_cause: assert property ($rose(buf_full) |-> $past(smp_valid, 2)) else $error("full without sample");
	a_status_full: assert property (host_rd && host_addr == 8'h08 |=> host_rdata[6] == host_rdata[5])
		else $error("full bit");
	cover property ($rose(buf_full));
	cover property ($fell(buf_watermark));
	cover property (trig_evt && ctl_q[7:6] == 2'h3);
endmodule // asf_sva

bind asf_top asf_sva chk (.sys_clk(sys_clk), .rst_b(rst_b), .smp_valid(smp_valid), .trig_evt(trig_evt),
	.host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata), .host_rd(host_rd),
	.host_rdata(host_rdata), .buf_full(buf_full), .buf_watermark(buf_watermark));

// ===== tb/asf_host.sv
// Host model: register reads, writes and bursts
// Assumes read data one cycle after the strobe
`timescale 1ns/10ps
module asf_host (
	input wire logic	sys_clk,
	input wire logic [7:0]	host_rdata,
	output logic [7:0]	host_addr = 8'h00,
	output logic	host_wr = 1'b0,
	output logic [7:0]	host_wdata = 8'h00,
	output logic	host_rd = 1'b0,
	output logic	host_txn_end = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(negedge sys_clk);
		host_wr = 1'b1;
		host_addr = a;
		host_wdata = dat;
		@(negedge sys_clk);
		host_wr = 1'b0;
		host_wdata = ~dat;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] dat);
		@(negedge sys_clk);
		host_rd = 1'b1;
		host_addr = a;
		@(negedge sys_clk);
		host_rd = 1'b0;
		host_txn_end = 1'b1;
		dat = host_rdata;
		@(negedge sys_clk);
		host_txn_end = 1'b0;
	endtask
	task automatic burst(output logic [7:0] b [0:5]);
		for (int j = 0; j < 7; j++) begin
			@(negedge sys_clk);
			if (j > 0)
				b[j-1] = host_rdata;
			host_rd = j < 6;
			host_addr = 8'h02 + 8'(j);
			host_txn_end = j == 6;
		end
		@(negedge sys_clk);
		host_txn_end = 1'b0;
	endtask
endmodule // asf_host

// ===== tb/accel_sample_fifo_bench.sv
// Bench for the sample buffer through its register port
// Assumes the host model for all register traffic
`timescale 1ns/10ps
module accel_sample_fifo_bench;
	logic	sys_clk = 1'b0, rst_b = 1'b0, smp_valid = 1'b0, trig_evt = 1'b0;
	logic	host_wr, host_rd, host_txn_end, buf_full, buf_watermark;
	logic [11:0]	smp_x = 12'h000, smp_y = 12'h000, smp_z = 12'h000;
	logic [7:0]	host_addr, host_wdata, host_rdata, d;
	logic [7:0]	b [0:5];
	int	failures = 0, check_count = 0;
	asf_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .smp_valid(smp_valid), .smp_x(smp_x), .smp_y(smp_y),
		.smp_z(smp_z), .trig_evt(trig_evt), .host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
		.host_rd(host_rd), .host_txn_end(host_txn_end), .host_rdata(host_rdata), .buf_full(buf_full),
		.buf_watermark(buf_watermark));
	asf_host host (.sys_clk(sys_clk), .host_rdata(host_rdata), .host_addr(host_addr), .host_wr(host_wr),
		.host_wdata(host_wdata), .host_rd(host_rd), .host_txn_end(host_txn_end));
	always #12.5 sys_clk = ~sys_clk;
	function automatic logic [11:0] v(input int k, input int i);
		return 12'(256 * (k + 1) + i);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		check(d, exp);
	endtask
	task automatic push(input int n, input int base);
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk);
			smp_valid = 1'b1;
			{smp_x, smp_y, smp_z} = {v(0, base + i), v(1, base + i), v(2, base + i)};
			@(negedge sys_clk);
			smp_valid = 1'b0;
			{smp_x, smp_y, smp_z} = ~{smp_x, smp_y, smp_z};
		end
	endtask
	task automatic pulse();
		@(negedge sys_clk);
		trig_evt = 1'b1;
		@(negedge sys_clk);
		trig_evt = 1'b0;
	endtask
	task automatic cs(input int i);
		logic [11:0] e;
		host.burst(b);
		for (int k = 0; k < 3; k++) begin
			e = v(k, i);
			check(b[2*k], {e[3:0], 4'h0});
			check(b[2*k+1], e[11:4]);
		end
	endtask
	initial begin
		repeat (16) @(negedge sys_clk);
		rst_b = 1'b1;
		host.wr(8'h08, 8'hff);
		for (int a = 2; a < 9; a++) rc(8'(a), 8'h00);
		rc(8'h14, 8'h00);
		rc(8'h01, 8'h00);
		$display("Test reset values done");
		push(1, 9);
		cs(9);
		rc(8'h08, 8'h00);
		$display("Test bypass done");
		for (int m = 1; m < 3; m++) begin
			host.wr(8'h14, 8'h00);
			rc(8'h08, 8'h00);
			host.wr(8'h14, {m[1:0], 6'h03});
			push(34, 0);
			rc(8'h08, 8'he0);
			check({7'h00, buf_full}, 8'h01);
			cs(0);
			cs(m);
			rc(8'h08, 8'h9e);
			$display("Test mode %0d done", m);
		end
		host.wr(8'h14, 8'h00);
		host.wr(8'h14, 8'hc4);
		push(10, 0);
		pulse();
		rc(8'h08, 8'h84);
		push(1, 10);
		pulse();
		rc(8'h08, 8'h85);
		cs(0);
		cs(6);
		rc(8'h08, 8'h03);
		check({7'h00, buf_watermark}, 8'h00);
		$display("Test trigger done");
		host.wr(8'h14, 8'h00);
		host.wr(8'h14, 8'h40);
		push(3, 0);
		host.rd(8'h02, d);
		cs(1);
		$display("Test single read done");
		// Reset in mid-run returns control, status and axis data to zero
		@(negedge sys_clk);
		rst_b = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		rc(8'h14, 8'h00);
		rc(8'h08, 8'h00);
		rc(8'h03, 8'h00);
		check({6'h00, buf_full, buf_watermark}, 8'h00);
		$display("Test mid-run reset done");
		conclude();
	end
	initial begin
		#1000000;
		failures++;
		conclude();
	end
endmodule // accel_sample_fifo_bench
